/* rtl/srwl_top.sv */
/*
 * System register write lock: key register, nine guarded control
 * registers, analog buffer configuration, identifier and reserved words.
 * Assumes a master that keeps the strobes one cycle long and exclusive.
 */
`default_nettype none
module srwl_top
(
	input  wire logic                       mclk_in,
	input  wire logic                       sys_rst_in,
	input  wire logic [srwl_pkg::AW-1:0]    addr_in,
	input  wire logic [31:0]                wdata_in,
	input  wire logic                       wr_in,
	input  wire logic                       rd_in,
	input  wire logic                       cmp_ref_request_in,
	input  wire logic                       adc_ref_request_in,
	output logic      [31:0]                rdata_out,
	output logic                            unlocked_out,
	output logic      [31:0]                oscillator_control_reg_out,
	output logic      [31:0]                system_pll_control_reg_out,
	output logic      [31:0]                fast_rc_tuning_reg_out,
	output logic      [31:0]                peripheral_disable_control_reg_out,
	output logic      [31:0]                software_reset_reg_out,
	output logic      [31:0]                pin_select_config_reg_out,
	output logic      [31:0]                nonmaskable_irq_control_reg_out,
	output logic      [31:0]                power_control_reg_out,
	output logic      [31:0]                calendar_clock_control_one_reg_out,
	output logic                            cmp_buffer_on_out,
	output logic                            adc_buffer_on_out
);
	import srwl_pkg::*;

	srwl_req_t       req;
	srwl_key_state_t key_state_q;
	srwl_key_state_t key_state_d;
	logic [31:0]     prot_q [NUM_PROT];
	logic [31:0]     analog_config_reg_q;
	logic [31:0]     rdata_q;
	logic [31:0]     rdata_d;
	logic [31:0]     uid_word;
	logic            key_wr;
	logic            is_prot;
	logic [3:0]      prot_idx;
	logic            is_uid;
	logic [2:0]      uid_idx;

	assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
	assign key_wr = req.wr && (req.addr == ADDR_KEY);
	assign is_prot = (req.addr >= ADDR_OSC_CTRL) &&
		(req.addr <= ADDR_CAL_CTRL1);
	assign prot_idx = 4'(req.addr - ADDR_OSC_CTRL);
	assign is_uid = (req.addr >= ADDR_UID_BASE) &&
		(req.addr < ADDR_UID_BASE + 10'(NUM_UID));
	// The store is only indexed on a read, so its word is zero otherwise.
	assign uid_idx = (req.rd && is_uid) ?
		3'(req.addr - ADDR_UID_BASE) : 3'h7;

	// Any bus write other than the second key or a repeated first key breaks the sequence,
	// so the two keys must land on back-to-back write operations.
	always_comb
	begin
		key_state_d = key_state_q;
		if (key_wr)
		begin
			unique case (key_state_q)
				KEY_IDLE:
					key_state_d = (req.wdata == KEY_FIRST) ?
						KEY_HALF : KEY_IDLE;
				KEY_HALF:
					if (req.wdata == KEY_SECOND)
						key_state_d = KEY_OPEN;
					else if (req.wdata == KEY_FIRST)
						key_state_d = KEY_HALF;
					else
						key_state_d = KEY_IDLE;
				KEY_OPEN:
					if ((req.wdata == KEY_FIRST) ||
						(req.wdata == KEY_SECOND))
						key_state_d = KEY_OPEN;
					else
						key_state_d = KEY_IDLE;
			endcase
		end
		else if (req.wr && (key_state_q == KEY_HALF))
			key_state_d = KEY_IDLE;
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
			key_state_q <= KEY_IDLE;
		else
			key_state_q <= key_state_d;
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
			unlocked_out <= 1'b0;
		else
			unlocked_out <= (key_state_d == KEY_OPEN);
	end

	// Locked writes vanish without a flag; software sees no fault.
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			for (int i = 0; i < NUM_PROT; i++)
				prot_q[i] <= PROT_RESET;
		end
		else if (req.wr && is_prot && (key_state_q == KEY_OPEN))
			prot_q[prot_idx] <= req.wdata;
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
			analog_config_reg_q <= ANALOG_CONFIG_REG_RESET;
		else if (req.wr && (req.addr == ADDR_ANALOG_CFG))
		begin
			analog_config_reg_q <= 32'h00000000;
			analog_config_reg_q[BIT_CMP_BUF] <= req.wdata[BIT_CMP_BUF];
			analog_config_reg_q[BIT_ADC_BUF] <= req.wdata[BIT_ADC_BUF];
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			cmp_buffer_on_out <= 1'b0;
			adc_buffer_on_out <= 1'b0;
		end
		else
		begin
			cmp_buffer_on_out <= cmp_ref_request_in ||
				analog_config_reg_q[BIT_CMP_BUF];
			adc_buffer_on_out <= adc_ref_request_in ||
				analog_config_reg_q[BIT_ADC_BUF];
		end
	end

	srwl_uid_rom u_uid (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.index_in   (uid_idx),
		.data_out   (uid_word)
	);

	// Reserved words and unmapped addresses read zero and drop writes,
	// which keeps a stray store from any register, but it still resets a half-entered key sequence.
	always_comb
	begin
		rdata_d = 32'h00000000;
		if (req.rd)
		begin
			if (req.addr == ADDR_KEY)
				rdata_d = {31'h0, key_state_q == KEY_OPEN};
			else if (is_prot)
				rdata_d = prot_q[prot_idx];
			else if (req.addr == ADDR_ANALOG_CFG)
				rdata_d = analog_config_reg_q;
			else if (req.addr == ADDR_BUF_STATUS)
				rdata_d = {29'h0, adc_buffer_on_out,
					cmp_buffer_on_out, 1'b0};
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
			rdata_q <= 32'h00000000;
		else
			rdata_q <= rdata_d;
	end

	// The identifier word already leaves its store registered, so it is
	// merged here instead of being registered twice; that keeps every
	// read answering in the cycle right after its strobe.
	assign rdata_out = rdata_q | uid_word;

	assign oscillator_control_reg_out         = prot_q[0];
	assign system_pll_control_reg_out         = prot_q[1];
	assign fast_rc_tuning_reg_out             = prot_q[2];
	assign peripheral_disable_control_reg_out = prot_q[3];
	assign software_reset_reg_out             = prot_q[4];
	assign pin_select_config_reg_out          = prot_q[5];
	assign nonmaskable_irq_control_reg_out    = prot_q[6];
	assign power_control_reg_out              = prot_q[7];
	assign calendar_clock_control_one_reg_out = prot_q[8];

endmodule : srwl_top
`default_nettype wire

/* rtl/srwl_uid_rom.sv */
/*
 * Read-only unique identifier store, five words, registered read data.
 * Assumes the identifier is fixed at build time and has no write path.
 */
`default_nettype none
module srwl_uid_rom
	import srwl_pkg::*;
#(
	parameter logic [159:0] UID_VALUE = UID_DEFAULT
) (
	input  wire logic        mclk_in,
	input  wire logic        sys_rst_in,
	input  wire logic [2:0]  index_in,
	output logic      [31:0] data_out
);

	logic [31:0] word_d;

	// No write port exists, so no erase or store can alter the words.
	always_comb
	begin
		word_d = 32'h00000000;
		if (index_in < 3'h5)
			word_d = UID_VALUE[32*index_in +: 32];
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
			data_out <= 32'h00000000;
		else
			data_out <= word_d;
	end

endmodule : srwl_uid_rom
`default_nettype wire

/* shared/srwl_pkg.sv */
/*
 * Constants and carrier types for the system register write lock.
 * Assumes a plain 32-bit register port with one-cycle strobes.
 */
`default_nettype none
package srwl_pkg;

	localparam logic [31:0] KEY_FIRST  = 32'haa996655;
	localparam logic [31:0] KEY_SECOND = 32'h556699aa;
	localparam logic [31:0] RELOCK_VAL = 32'h00000000;

	// Word addresses (byte address / 4) in one local 32-bit space.
	localparam int          AW                = 10;
	localparam logic [9:0]  ADDR_KEY          = 10'h000;
	localparam logic [9:0]  ADDR_OSC_CTRL     = 10'h001;
	localparam logic [9:0]  ADDR_PLL_CTRL     = 10'h002;
	localparam logic [9:0]  ADDR_FRC_TUNE     = 10'h003;
	localparam logic [9:0]  ADDR_PERIPH_DIS   = 10'h004;
	localparam logic [9:0]  ADDR_SW_RESET     = 10'h005;
	localparam logic [9:0]  ADDR_PIN_SELECT   = 10'h006;
	localparam logic [9:0]  ADDR_NMI_CTRL     = 10'h007;
	localparam logic [9:0]  ADDR_PWR_CTRL     = 10'h008;
	localparam logic [9:0]  ADDR_CAL_CTRL1    = 10'h009;
	localparam logic [9:0]  ADDR_ANALOG_CFG   = 10'h00a;
	localparam logic [9:0]  ADDR_BUF_STATUS   = 10'h00b;
	localparam logic [9:0]  ADDR_UID_BASE     = 10'h010;
	localparam logic [9:0]  ADDR_RSVD0        = 10'h020;
	localparam logic [9:0]  ADDR_RSVD1        = 10'h021;
	localparam logic [9:0]  ADDR_RSVD2        = 10'h022;

	localparam int          NUM_PROT          = 9;
	localparam int          NUM_UID           = 5;
	localparam logic [31:0] PROT_RESET        = 32'h00000000;
	localparam logic [31:0] ANALOG_CONFIG_REG_RESET       = 32'h00000000;
	localparam int          BIT_CMP_BUF       = 1;
	localparam int          BIT_ADC_BUF       = 2;

	// Arbitrary neutral identifier value; the real one is fused.
	localparam logic [159:0] UID_DEFAULT =
		160'h0123456789abcdef0011223344556677_8899aabb;

	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_HALF,
		KEY_OPEN
	} srwl_key_state_t;

	typedef struct packed {
		logic          wr;
		logic          rd;
		logic [AW-1:0] addr;
		logic [31:0]   wdata;
	} srwl_req_t;

endpackage : srwl_pkg
`default_nettype wire

/* testbench/srwl_checker.sv */
/*
 * Port assertions for the system register write lock.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`default_nettype none
module srwl_checker
	import srwl_pkg::*;
(
	input wire logic          mclk_in,
	input wire logic          sys_rst_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [31:0]   wdata_in,
	input wire logic          wr_in,
	input wire logic          rd_in,
	input wire logic          cmp_ref_request_in,
	input wire logic          adc_ref_request_in,
	input wire logic [31:0]   rdata_out,
	input wire logic          unlocked_out,
	input wire logic [31:0]   oscillator_control_reg_out,
	input wire logic          cmp_buffer_on_out,
	input wire logic          adc_buffer_on_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic kw;
	assign kw = wr_in && addr_in == ADDR_KEY;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_k1;
		kw && wdata_in == KEY_FIRST;
	endsequence
	sequence s_k2;
		kw && wdata_in == KEY_SECOND;
	endsequence
	a_unlock_keys: assert property (s_k1 ##1 s_k2 |=> unlocked_out)
		else $error("unlock sequence did not open");
	a_stay_locked: assert property (!unlocked_out && !kw |=> !unlocked_out)
		else $error("lock opened without key");
	// A stray write between the keys must not leave a half-open state.
	a_broken_keys: assert property (!unlocked_out ##0 s_k1 ##1
		(wr_in && !kw) ##1 s_k2 |=> !unlocked_out)
		else $error("interrupted keys opened lock");
	a_relock_write: assert property (kw && wdata_in != KEY_FIRST &&
		wdata_in != KEY_SECOND |=> !unlocked_out)
		else $error("non-key write did not relock");
	a_locked_drop: assert property (!unlocked_out |=>
		$stable(oscillator_control_reg_out))
		else $error("guarded register changed while locked");
	a_guard_write: assert property (unlocked_out && wr_in &&
		addr_in == ADDR_OSC_CTRL |=>
		oscillator_control_reg_out == $past(wdata_in))
		else $error("unlocked write not taken");
	a_key_read: assert property (rd_in && addr_in == ADDR_KEY |=>
		rdata_out == {31'h0, $past(unlocked_out)})
		else $error("key read wrong");
	a_cmp_request: assert property (cmp_ref_request_in |=> cmp_buffer_on_out)
		else $error("comparator buffer off on request");
	a_adc_request: assert property (adc_ref_request_in |=> adc_buffer_on_out)
		else $error("converter buffer off on request");
endmodule : srwl_checker
bind srwl_top srwl_checker chk_u (.mclk_in, .sys_rst_in, .addr_in,
	.wdata_in, .wr_in, .rd_in, .cmp_ref_request_in, .adc_ref_request_in,
	.rdata_out, .unlocked_out, .oscillator_control_reg_out,
	.cmp_buffer_on_out, .adc_buffer_on_out);
`default_nettype wire

/* testbench/tb_top.sv */
/*
 * Self-checking bench for the system register write lock.
 * Assumes the design package and a 50 MHz clock on mclk_in.
 */
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import srwl_pkg::*;
	logic          mclk_in, sys_rst_in, wr_in, rd_in, creq, areq;
	logic          unlocked_out, cmp_on, adc_on;
	logic [AW-1:0] addr_in;
	logic [31:0]   wdata_in, rdata_out;
	logic [31:0]   g [NUM_PROT];
	int            errors, checks;
	srwl_top dut_u (.mclk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in,
		.rd_in, .cmp_ref_request_in(creq), .adc_ref_request_in(areq),
		.rdata_out, .unlocked_out, .oscillator_control_reg_out(g[0]),
		.system_pll_control_reg_out(g[1]), .fast_rc_tuning_reg_out(g[2]),
		.peripheral_disable_control_reg_out(g[3]),
		.software_reset_reg_out(g[4]), .pin_select_config_reg_out(g[5]),
		.nonmaskable_irq_control_reg_out(g[6]),
		.power_control_reg_out(g[7]),
		.calendar_clock_control_one_reg_out(g[8]),
		.cmp_buffer_on_out(cmp_on), .adc_buffer_on_out(adc_on));
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
	endtask : wr
	// Ends one edge after the last strobe so results have landed.
	task automatic idle;
		@(posedge mclk_in);
		wr_in <= 1'b0;
		#1;
	endtask : idle
	task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
		@(posedge mclk_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1;
		`CHK("rdata", e, rdata_out)
	endtask : rd
	task automatic wr_all(input logic [31:0] base);
		for (int i = 0; i < NUM_PROT; i++)
			wr(ADDR_OSC_CTRL + 10'(i), base + i);
		idle;
	endtask : wr_all
	task automatic t_guard;
		wr_all(32'hffff0000);
		for (int i = 0; i < NUM_PROT; i++)
			`CHK("locked", PROT_RESET, g[i])
		wr(ADDR_KEY, KEY_FIRST);
		wr(ADDR_KEY, KEY_SECOND);
		idle;
		`CHK("unlocked", 1'b1, unlocked_out)
		rd(ADDR_KEY, 32'h1);
		wr_all(32'ha5a50000);
		for (int i = 0; i < NUM_PROT; i++)
			`CHK("open", 32'ha5a50000 + i, g[i])
		wr(ADDR_KEY, RELOCK_VAL);
		idle;
		`CHK("relock", 1'b0, unlocked_out)
		rd(ADDR_KEY, 32'h0);
		wr(ADDR_OSC_CTRL, 32'h0);
		idle;
		`CHK("kept", 32'ha5a50000, g[0])
	endtask : t_guard
	task automatic t_bad_key;
		wr(ADDR_KEY, KEY_FIRST);
		wr(ADDR_PLL_CTRL, 32'h0);
		wr(ADDR_KEY, KEY_SECOND);
		idle;
		`CHK("gap", 1'b0, unlocked_out)
		`CHK("pll", 32'ha5a50001, g[1])
		rd(ADDR_PLL_CTRL, 32'ha5a50001);
		wr(ADDR_KEY, KEY_FIRST);
		wr(ADDR_KEY, 32'h12345678);
		wr(ADDR_KEY, KEY_SECOND);
		idle;
		`CHK("wrong", 1'b0, unlocked_out)
	endtask : t_bad_key
	task automatic t_buffers;
		@(posedge mclk_in);
		creq <= 1'b1;
		areq <= 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		`CHK("cmp req", 1'b1, cmp_on)
		`CHK("adc req", 1'b1, adc_on)
		@(posedge mclk_in);
		creq <= 1'b0;
		areq <= 1'b0;
		wr(ADDR_ANALOG_CFG, 32'h4);
		idle;
		@(posedge mclk_in);
		#1;
		`CHK("cmp off", 1'b0, cmp_on)
		`CHK("adc force", 1'b1, adc_on)
		wr(ADDR_ANALOG_CFG, 32'h2);
		idle;
		@(posedge mclk_in);
		#1;
		`CHK("cmp force", 1'b1, cmp_on)
		`CHK("adc off", 1'b0, adc_on)
		rd(ADDR_ANALOG_CFG, 32'h2);
		rd(ADDR_BUF_STATUS, 32'h2);
		rd(10'h3ff, 32'h0);
	endtask : t_buffers
	task automatic t_ident;
		rd(ADDR_UID_BASE, UID_DEFAULT[31:0]);
		rd(ADDR_UID_BASE + 10'h4, UID_DEFAULT[159:128]);
		wr(ADDR_UID_BASE, 32'h0);
		rd(ADDR_UID_BASE, UID_DEFAULT[31:0]);
		rd(ADDR_RSVD0, 32'h0);
	endtask : t_ident
	task automatic report_and_stop;
		if (errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	initial
	begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end
	initial
	begin
		{sys_rst_in, wr_in, rd_in, creq, areq} = 5'h10;
		addr_in = '0;
		wdata_in = '0;
		repeat (4) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		rd(ADDR_KEY, 32'h0);
		t_guard;
		t_bad_key;
		t_buffers;
		t_ident;
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
